// ---- common/egs_pkg.sv ----
package egs_pkg;
	// register map, byte addresses
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_NUM = 5'h04;
	localparam logic [4:0] OFF_DEN = 5'h08;
	localparam logic [4:0] OFF_STATUS = 5'h0C;
	localparam logic [4:0] OFF_INT_STAT = 5'h10;
	localparam logic [4:0] OFF_INT_MASK = 5'h14;
	localparam logic [4:0] OFF_RES_LO = 5'h18;
	localparam logic [4:0] OFF_RES_HI = 5'h1C;
	// field positions
	localparam int CTRL_RESTART_BIT = 0;
	localparam int CTRL_COMPAT_BIT = 1;
	localparam int STS_ALARM_BIT = 0;
	localparam int STS_BUSY_BIT = 1;
	localparam int STS_COMPAT_BIT = 2;
	localparam int INT_ALARM_BIT = 0;
	localparam int INT_DONE_BIT = 1;
	localparam int INT_W = 2;
	// gear settings
	localparam int GEAR_W = 31;
	localparam int REF_W = 32;
	localparam int ACC_W = 64;
	localparam int DIV_STEPS = 64;
	localparam logic [30:0] GEAR_MAX = 31'h40000000;
	localparam logic [30:0] NUM_RESET = 31'h00000010;
	localparam logic [30:0] DEN_RESET = 31'h00000001;
	localparam logic COMPAT_RESET = 1'b0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	// ratio limits: B/A >= 1/RATIO_MIN_INV, B/A <= RATIO_MAX_*
	localparam logic [15:0] RATIO_MIN_INV = 16'h03E8;
	localparam logic [15:0] RATIO_MAX_NATIVE = 16'hFA00;
	localparam logic [15:0] RATIO_MAX_20BIT = 16'h0FA0;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} egs_state_t;
endpackage

// ---- common/egs_div_if.sv ----
`timescale 1ns/10ps
interface egs_div_if;
	logic        start;
	logic [63:0] dividend;
	logic [30:0] divisor;
	logic        busy;
	logic        done;
	logic [63:0] quotient;
	logic [30:0] remainder;
	modport master (output start, dividend, divisor, input busy, done, quotient, remainder);
	modport worker (input start, dividend, divisor, output busy, done, quotient, remainder);
endinterface

// ---- rtl/egs_divider.sv ----
`timescale 1ns/10ps
module egs_divider (
	// clock, reset, enable
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       ce,
	// request and result
	egs_div_if.worker      div
);
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [6:0]  cnt;
		logic [63:0] quo;
		logic [31:0] rem;
		logic [30:0] dsr;
	} egs_div_state_t;

	egs_div_state_t r;
	egs_div_state_t next_r;
	logic [31:0]    trial;

	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		trial = {r.rem[30:0], r.quo[63]};
		if (div.start && !r.busy)
		begin
			next_r.busy = 1'b1;
			next_r.cnt = 7'(egs_pkg::DIV_STEPS);
			next_r.quo = div.dividend;
			next_r.rem = 32'h00000000;
			next_r.dsr = div.divisor;
		end
		else if (r.busy)
		begin
			// restoring step: shift one dividend bit in, subtract if it fits
			next_r.quo = {r.quo[62:0], 1'b0};
			if (trial >= {1'b0, r.dsr})
			begin
				next_r.rem = trial - {1'b0, r.dsr};
				next_r.quo[0] = 1'b1;
			end
			else
				next_r.rem = trial;
			next_r.cnt = r.cnt - 7'h01;
			if (r.cnt == 7'h01)
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= '0;
		else if (ce)
			r <= next_r;
	end

	assign div.busy = r.busy;
	assign div.done = r.done;
	assign div.quotient = r.quo;
	assign div.remainder = r.rem[30:0];

	logic [63:0] chk_dividend;
	always_ff @(posedge aclk)
	begin
		if (ce && div.start && !r.busy)
			chk_dividend <= div.dividend;
	end

	property p_div_exact;
		@(posedge aclk) disable iff (!aresetn)
		r.done |-> (r.quo * {33'h0, r.dsr} + {32'h0, r.rem} == chk_dividend) && (r.rem < {1'b0, r.dsr});
	endproperty
	a_div_exact: assert property (p_div_exact) else $error("divider result does not match dividend");
endmodule

// ---- rtl/egs_top.sv ----
// Behaviour
// - Each commanded travel in reference units is converted into the matching count of encoder pulses.
// - Every accepted reference word is taken as a count of reference units and goes straight into gearing.
// - The pulse count is the reference amount times gear_numerator divided by gear_denominator.
// - With resolution_compat_select at 0 a ratio from 0.001 to 64000 inclusive is accepted.
// - With resolution_compat_select at 1 only a ratio from 0.001 to 4000 inclusive is accepted.
// - A ratio outside the allowed range raises the parameter setting error alarm.
// - Numerator and denominator run from 1 to 1073741824, reset to 16 and 1, and act only after a restart.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module egs_top (
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write address
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output wire logic        s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output wire logic        s_axi_wready,
	// axi4-lite write response
	output wire logic [1:0]  s_axi_bresp,
	output wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output wire logic        s_axi_arready,
	// axi4-lite read data
	output wire logic [31:0] s_axi_rdata,
	output wire logic [1:0]  s_axi_rresp,
	output wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// position reference from host
	input  wire logic        ref_valid,
	output wire logic        ref_ready,
	input  wire logic [31:0] ref_units,
	// scaled pulse output
	output wire logic        pulse_valid,
	output wire logic [63:0] pulse_count,
	// alarm and interrupt
	output wire logic        param_error_alarm,
	output wire logic        irq
);
	typedef struct packed {
		egs_pkg::egs_state_t state;
		logic        aw_ok;
		logic [4:0]  aw_addr;
		logic        w_ok;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [30:0] pend_num;
		logic [30:0] pend_den;
		logic        pend_compat;
		logic        restart_pend;
		logic [30:0] act_num;
		logic [30:0] act_den;
		logic        act_compat;
		logic        alarm;
		logic [1:0]  int_stat;
		logic [1:0]  int_mask;
		logic [30:0] rem;
		logic [63:0] total;
		logic        div_start;
		logic        out_valid;
		logic [63:0] pulses;
	} egs_top_state_t;

	localparam egs_top_state_t RESET_STATE = '{
		state: egs_pkg::ST_IDLE,
		pend_num: egs_pkg::NUM_RESET,
		pend_den: egs_pkg::DEN_RESET,
		pend_compat: egs_pkg::COMPAT_RESET,
		act_num: egs_pkg::NUM_RESET,
		act_den: egs_pkg::DEN_RESET,
		act_compat: egs_pkg::COMPAT_RESET,
		int_mask: egs_pkg::MASK_RESET,
		default: '0
	};

	egs_top_state_t r;
	egs_top_state_t next_r;
	egs_div_if      div ();

	function automatic logic in_range(input logic [30:0] v);
		return (v != 31'h0) && (v <= egs_pkg::GEAR_MAX);
	endfunction

	// ratio check against the limit set by the compat select
	function automatic logic ratio_ok(input logic [30:0] num, input logic [30:0] den, input logic compat);
		logic [46:0] lo;
		logic [46:0] hi;
		lo = {16'h0, num} * {31'h0, egs_pkg::RATIO_MIN_INV};
		hi = {16'h0, den} * {31'h0, (compat ? egs_pkg::RATIO_MAX_20BIT : egs_pkg::RATIO_MAX_NATIVE)};
		return in_range(num) && in_range(den) && (lo >= {16'h0, den}) && ({16'h0, num} <= hi);
	endfunction

	function automatic logic [30:0] merge(input logic [30:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] v;
		v = {1'b0, old};
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				v[i*8 +: 8] = data[i*8 +: 8];
		end
		return v[30:0];
	endfunction

	logic               do_write;
	logic               restart_req;
	logic [1:0]         int_set;
	logic [1:0]         int_clr;
	logic signed [63:0] prod;
	logic [63:0]        mag;
	logic               take_ref;

	always_comb
	begin
		next_r = r;
		int_set = 2'h0;
		int_clr = 2'h0;
		restart_req = 1'b0;
		do_write = r.aw_ok && r.w_ok && !r.bvalid;
		take_ref = ref_valid && ref_ready;
		// signed reference times numerator plus carried remainder
		prod = $signed({{32{ref_units[31]}}, ref_units}) * $signed({33'h0, r.act_num});
		mag = r.total[63] ? (64'h0 - r.total) : r.total;
		next_r.div_start = 1'b0;
		next_r.out_valid = 1'b0;

		// write channel capture, either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_r.aw_ok = 1'b1;
			next_r.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_r.w_ok = 1'b1;
			next_r.w_data = s_axi_wdata;
			next_r.w_strb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready)
			next_r.bvalid = 1'b0;
		if (do_write)
		begin
			next_r.aw_ok = 1'b0;
			next_r.w_ok = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = egs_pkg::RESP_OKAY;
			case ({r.aw_addr[4:2], 2'b00})
				egs_pkg::OFF_CTRL:
				begin
					if (r.w_strb[0])
					begin
						next_r.pend_compat = r.w_data[egs_pkg::CTRL_COMPAT_BIT];
						restart_req = r.w_data[egs_pkg::CTRL_RESTART_BIT];
					end
				end
				egs_pkg::OFF_NUM:
					next_r.pend_num = merge(r.pend_num, r.w_data, r.w_strb);
				egs_pkg::OFF_DEN:
					next_r.pend_den = merge(r.pend_den, r.w_data, r.w_strb);
				egs_pkg::OFF_INT_STAT:
				begin
					if (r.w_strb[0])
						int_clr = r.w_data[egs_pkg::INT_W-1:0];
				end
				egs_pkg::OFF_INT_MASK:
				begin
					if (r.w_strb[0])
						next_r.int_mask = r.w_data[egs_pkg::INT_W-1:0];
				end
				egs_pkg::OFF_STATUS, egs_pkg::OFF_RES_LO, egs_pkg::OFF_RES_HI:
					next_r.bresp = egs_pkg::RESP_OKAY;
				default:
					next_r.bresp = egs_pkg::RESP_SLVERR;
			endcase
		end
		if (restart_req)
			next_r.restart_pend = 1'b1;

		// read channel
		if (r.rvalid && s_axi_rready)
			next_r.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_r.rvalid = 1'b1;
			next_r.rresp = egs_pkg::RESP_OKAY;
			next_r.rdata = 32'h00000000;
			case ({s_axi_araddr[4:2], 2'b00})
				egs_pkg::OFF_CTRL:
					next_r.rdata[egs_pkg::CTRL_COMPAT_BIT] = r.pend_compat;
				egs_pkg::OFF_NUM:
					next_r.rdata = {1'b0, r.pend_num};
				egs_pkg::OFF_DEN:
					next_r.rdata = {1'b0, r.pend_den};
				egs_pkg::OFF_STATUS:
				begin
					next_r.rdata[egs_pkg::STS_ALARM_BIT] = r.alarm;
					next_r.rdata[egs_pkg::STS_BUSY_BIT] = (r.state != egs_pkg::ST_IDLE) || r.restart_pend;
					next_r.rdata[egs_pkg::STS_COMPAT_BIT] = r.act_compat;
				end
				egs_pkg::OFF_INT_STAT:
					next_r.rdata[egs_pkg::INT_W-1:0] = r.int_stat;
				egs_pkg::OFF_INT_MASK:
					next_r.rdata[egs_pkg::INT_W-1:0] = r.int_mask;
				egs_pkg::OFF_RES_LO:
					next_r.rdata = r.pulses[31:0];
				egs_pkg::OFF_RES_HI:
					next_r.rdata = r.pulses[63:32];
				default:
					next_r.rresp = egs_pkg::RESP_SLVERR;
			endcase
		end

		// conversion sequence
		case (r.state)
			egs_pkg::ST_IDLE:
			begin
				if (r.restart_pend)
				begin
					// settings move to the active set only here, never mid-conversion
					next_r.restart_pend = restart_req;
					next_r.act_num = r.pend_num;
					next_r.act_den = r.pend_den;
					next_r.act_compat = r.pend_compat;
					next_r.rem = 31'h0;
					next_r.alarm = !ratio_ok(r.pend_num, r.pend_den, r.pend_compat);
					int_set[egs_pkg::INT_ALARM_BIT] = next_r.alarm;
				end
				else if (take_ref)
				begin
					// reference word counts directly as reference units
					next_r.total = 64'(prod + $signed({33'h0, r.rem}));
					next_r.div_start = 1'b1;
					next_r.state = egs_pkg::ST_WAIT;
				end
			end
			egs_pkg::ST_WAIT:
			begin
				if (div.done)
				begin
					// floor division keeps remainder in 0..den-1 for either sign
					if (!r.total[63])
					begin
						next_r.pulses = div.quotient;
						next_r.rem = div.remainder;
					end
					else if (div.remainder == 31'h0)
					begin
						next_r.pulses = 64'h0 - div.quotient;
						next_r.rem = 31'h0;
					end
					else
					begin
						next_r.pulses = 64'h0 - div.quotient - 64'h1;
						next_r.rem = r.act_den - div.remainder;
					end
					next_r.out_valid = 1'b1;
					int_set[egs_pkg::INT_DONE_BIT] = 1'b1;
					next_r.state = egs_pkg::ST_IDLE;
				end
			end
			default:
				next_r.state = egs_pkg::ST_IDLE;
		endcase

		// set wins over a same-cycle clear
		next_r.int_stat = (r.int_stat & ~int_clr) | int_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= RESET_STATE;
		else if (ce)
			r <= next_r;
	end

	egs_divider u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.div     (div)
	);

	assign div.start = r.div_start;
	assign div.dividend = mag;
	assign div.divisor = r.act_den;

	assign s_axi_awready = ce && !r.aw_ok && !r.bvalid;
	assign s_axi_wready = ce && !r.w_ok && !r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = ce && !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	// alarmed ratio blocks all motion references; no ready while frozen, so nothing is lost
	assign ref_ready = ce && (r.state == egs_pkg::ST_IDLE) && !r.restart_pend && !r.alarm && !div.busy;
	assign pulse_valid = r.out_valid;
	assign pulse_count = r.pulses;
	assign param_error_alarm = r.alarm;
	assign irq = |(r.int_stat & r.int_mask);

	property p_pulse_exact;
		@(posedge aclk) disable iff (!aresetn)
		r.out_valid |-> (r.pulses * {33'h0, r.act_den} + {33'h0, r.rem} == r.total);
	endproperty
	a_pulse_exact: assert property (p_pulse_exact) else $error("pulse count times denominator mismatch");

	property p_rem_bound;
		@(posedge aclk) disable iff (!aresetn)
		(r.state == egs_pkg::ST_IDLE) |-> (r.rem < r.act_den) || (r.act_den == 31'h0);
	endproperty
	a_rem_bound: assert property (p_rem_bound) else $error("carried remainder not below denominator");

	property p_ref_starts;
		@(posedge aclk) disable iff (!aresetn)
		(take_ref && ce) |=> (r.state == egs_pkg::ST_WAIT) && r.div_start && !ref_ready;
	endproperty
	a_ref_starts: assert property (p_ref_starts) else $error("accepted reference did not start conversion");

	property p_native_ok;
		@(posedge aclk) disable iff (!aresetn)
		(!r.act_compat && ratio_ok(r.act_num, r.act_den, 1'b0)) |-> !param_error_alarm;
	endproperty
	a_native_ok: assert property (p_native_ok) else $error("alarm on valid native ratio");

	property p_compat_limit;
		@(posedge aclk) disable iff (!aresetn)
		(r.act_compat && ({16'h0, r.act_num} > {16'h0, r.act_den} * {31'h0, egs_pkg::RATIO_MAX_20BIT}))
			|-> param_error_alarm;
	endproperty
	a_compat_limit: assert property (p_compat_limit) else $error("no alarm above 20-bit ratio limit");

	property p_alarm_match;
		@(posedge aclk) disable iff (!aresetn)
		param_error_alarm == !ratio_ok(r.act_num, r.act_den, r.act_compat);
	endproperty
	a_alarm_match: assert property (p_alarm_match) else $error("alarm disagrees with active ratio");

	property p_restart_latch;
		@(posedge aclk) disable iff (!aresetn)
		(ce && !r.restart_pend) ##1 (ce && !r.restart_pend) |-> $stable(r.act_num) && $stable(r.act_den);
	endproperty
	a_restart_latch: assert property (p_restart_latch) else $error("gear setting changed without restart");

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		(ce && int_set[egs_pkg::INT_DONE_BIT]) |=> r.int_stat[egs_pkg::INT_DONE_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("done event lost against clear");

	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(r.bvalid && !s_axi_bready) |=> r.bvalid && $stable(r.bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped before bready");
endmodule

// ---- verification/egs_host_model.sv ----
`timescale 1ns/10ps
module egs_host_model (
	// clock
	input  wire logic        aclk,
	// reference link
	input  wire logic        ref_ready,
	output logic             ref_valid,
	output logic [31:0]      ref_units
);
	initial
	begin
		ref_valid = 1'b0;
		ref_units = 32'h00000000;
	end
	// holds the word until the edge that takes it, then scrambles the idle bus
	task automatic send(input logic [31:0] u, output logic taken);
		int n;
		taken = 1'b0;
		@(posedge aclk);
		ref_valid <= 1'b1;
		ref_units <= u;
		for (n = 0; n < 200 && !taken; n++)
		begin
			@(negedge aclk);
			taken = ref_ready;
			@(posedge aclk);
		end
		ref_valid <= 1'b0;
		ref_units <= ~u;
	endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic        aclk, aresetn, ce;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, ref_units, d, x;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, ref_valid, ref_ready;
	logic        pulse_valid, param_error_alarm, irq, ok;
	logic [63:0] pulse_count, mq;
	int          failures, cmp_count, i;
	longint      mnum, mden, mrem;
	longint      tn [9] = '{1, 1, 64000, 64001, 4000, 4001, 0, 1073741824, 1073741824};
	longint      td [9] = '{1000, 1001, 1, 1, 1, 1, 1, 1073741824, 1};
	bit          tc [9] = '{0, 0, 0, 0, 1, 1, 0, 0, 0};

	egs_top u_egs_top (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.ce                (ce),
		.s_axi_awaddr      (awaddr),
		.s_axi_awprot      (3'h0),
		.s_axi_awvalid     (awvalid),
		.s_axi_awready     (awready),
		.s_axi_wdata       (wdata),
		.s_axi_wstrb       (4'hF),
		.s_axi_wvalid      (wvalid),
		.s_axi_wready      (wready),
		.s_axi_bresp       (bresp),
		.s_axi_bvalid      (bvalid),
		.s_axi_bready      (bready),
		.s_axi_araddr      (araddr),
		.s_axi_arprot      (3'h0),
		.s_axi_arvalid     (arvalid),
		.s_axi_arready     (arready),
		.s_axi_rdata       (rdata),
		.s_axi_rresp       (rresp),
		.s_axi_rvalid      (rvalid),
		.s_axi_rready      (rready),
		.ref_valid         (ref_valid),
		.ref_ready         (ref_ready),
		.ref_units         (ref_units),
		.pulse_valid       (pulse_valid),
		.pulse_count       (pulse_count),
		.param_error_alarm (param_error_alarm),
		.irq               (irq)
	);
	egs_host_model u_egs_host_model (
		.aclk      (aclk),
		.ref_ready (ref_ready),
		.ref_valid (ref_valid),
		.ref_units (ref_units)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reset_check;
		@(negedge aclk);
		chk(pulse_count, 64'h0);
		chk(pulse_valid, 1'b0);
		chk(param_error_alarm, 1'b0);
		chk(irq, 1'b0);
		chk(ref_ready, 1'b1);
		{mnum, mden, mrem} = {64'd16, 64'd1, 64'd0};
		axr(egs_pkg::OFF_NUM, d);
		chk(d, 32'h00000010);
		axr(egs_pkg::OFF_DEN, d);
		chk(d, 32'h00000001);
		axr(egs_pkg::OFF_STATUS, d);
		chk(d, 32'h00000000);
	endtask
	task automatic axw(input logic [4:0] a, input logic [31:0] v);
		logic ta, tw;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		while (!(ta && tw))
		begin
			@(negedge aclk);
			ta = ta || awready;
			tw = tw || wready;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		ta = 1'b0;
		while (!ta)
		begin
			@(negedge aclk);
			ta = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		chk(r, egs_pkg::RESP_OKAY);
	endtask
	task automatic axr(input logic [4:0] a, output logic [31:0] v);
		logic t;
		logic [1:0] rr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = rvalid;
			v = rdata;
			rr = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		chk(rr, egs_pkg::RESP_OKAY);
	endtask
	// reference model: floor division with the remainder carried forward
	task automatic conv(input logic [31:0] u);
		logic tk;
		longint tot, q;
		int n;
		u_egs_host_model.send(u, tk);
		chk(tk, 1'b1);
		@(negedge aclk);
		chk(ref_ready, 1'b0);
		tot = longint'($signed(u)) * mnum + mrem;
		q = tot / mden;
		if (tot % mden < 0)
			q = q - 1;
		mrem = tot - q * mden;
		for (n = 0; n < 200 && pulse_valid !== 1'b1; n++)
			@(negedge aclk);
		chk(pulse_valid, 1'b1);
		chk(pulse_count, q);
		mq = q;
	endtask
	task automatic restart(input longint nm, input longint dn, input bit cp, output logic good);
		logic [31:0] v;
		int n;
		axw(egs_pkg::OFF_NUM, nm[31:0]);
		axw(egs_pkg::OFF_DEN, dn[31:0]);
		axw(egs_pkg::OFF_CTRL, {30'h0, cp, 1'b1});
		v = 32'h00000002;
		for (n = 0; n < 50 && v[egs_pkg::STS_BUSY_BIT]; n++)
			axr(egs_pkg::OFF_STATUS, v);
		good = nm >= 1 && dn >= 1 && nm <= 2**30 && dn <= 2**30 && 1000 * nm >= dn && nm <= dn * (cp ? 4000 : 64000);
		mnum = nm;
		mden = dn;
		mrem = 0;
		chk(param_error_alarm, !good);
		chk(v[egs_pkg::STS_ALARM_BIT], !good);
		chk(v[egs_pkg::STS_COMPAT_BIT], cp);
		axr(egs_pkg::OFF_INT_STAT, v);
		chk(v[egs_pkg::INT_ALARM_BIT], !good);
		axw(egs_pkg::OFF_INT_STAT, 32'h00000003);
		@(negedge aclk);
		chk(ref_ready, good);
	endtask

	initial
	begin
		aclk = 1'b0;
		forever
			#2 aclk = ~aclk;
	end
	initial
	begin
		repeat (40000) @(posedge aclk);
		failures++;
		$display("watchdog expired");
		summarize();
	end
	initial
	begin
		{aresetn, ce, awvalid, wvalid, bready, arvalid, rready} = 7'b0100000;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h00000000;
		failures = 0;
		cmp_count = 0;
		x = 32'hA53A;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		reset_check();
		axr(egs_pkg::OFF_INT_MASK, d);
		chk(d, 32'h00000000);
		axw(egs_pkg::OFF_STATUS, 32'hFFFFFFFF);
		axr(egs_pkg::OFF_STATUS, d);
		chk(d, 32'h00000000);
		$display("test reset done");
		conv(32'd10000);
		axr(egs_pkg::OFF_RES_LO, d);
		chk(d, 32'd160000);
		axw(egs_pkg::OFF_NUM, 32'h00000005);
		conv(32'd3);
		$display("test pending done");
		restart(7, 3, 1'b0, ok);
		for (i = 0; i < 8; i++)
		begin
			x = lfsr(x);
			conv(i < 4 ? {28'h0, x[3:0]} : x);
		end
		restart(1, 1, 1'b0, ok);
		conv(x);
		$display("test carry done");
		for (i = 0; i < 9; i++)
		begin
			restart(tn[i], td[i], tc[i], ok);
			x = lfsr(x);
			if (ok)
				conv(x);
		end
		$display("test limits done");
		restart(3, 2, 1'b1, ok);
		axw(egs_pkg::OFF_INT_MASK, 32'h00000002);
		conv(x);
		chk(irq, 1'b1);
		axw(egs_pkg::OFF_INT_STAT, 32'h00000002);
		@(negedge aclk);
		chk(irq, 1'b0);
		axw(egs_pkg::OFF_INT_MASK, 32'h00000000);
		conv(32'hFFFFFFFF);
		chk(irq, 1'b0);
		axr(egs_pkg::OFF_RES_HI, d);
		chk(d, mq[63:32]);
		$display("test interrupt done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		reset_check();
		conv(32'd7);
		fork
			conv(32'd5);
			begin
				repeat (40) @(posedge aclk);
				ce <= 1'b0;
				repeat (40) @(posedge aclk);
				@(negedge aclk);
				chk(pulse_count, mq);
				@(posedge aclk);
				ce <= 1'b1;
			end
		join
		$display("test reset and enable done");
		summarize();
	end
endmodule
